// ==== common/spo_pkg.sv ====
// Purpose: Shared constants for the scanner program output card
// Assumes: Digits arrive as 4-bit BCD with a one-cycle strobe
// Notes: No software registers; jumper is a plain input
//
// Overview of operation
// RULE1: Continuous mode: advance after last channel returns to channel 1.
// RULE2: End-of-transmission character gives one store strobe to the scanner. Code gives none after a home-only string.
// RULE3: Jumper position 8: output command sends scanner home at once.
// RULE4: Jumper inverted-8: command alone never homes; only home digits do.
// RULE5: Home request is digit 1 then 80; later digits ignored. Code homes on 1 then 8 without checking the third digit.
// RULE6: Home clears the scan counter and opens every channel.
// RULE7: New command mid-scan homes; next advance selects channel 1.
// RULE8: Jumper 8: digits right after the command become the new setup.
// RULE9: Random mode passes the programmed channel straight to the scanner.
// RULE10: Controller should home the scanner before changing scan mode.
// RULE11: Digit source marks end of transmission by pulling done low.
// RULE12: Programmed digits stay stable on outputs until the next command.
package spo_pkg;

   // ************************************
   // Digit codes and layout
   // ************************************
   localparam logic [3:0] DIG_ENABLE = 4'h1;
   localparam logic [3:0] DIG_HOME = 4'h8;
   localparam logic [3:0] DIG_ZERO = 4'h0;
   localparam int NUM_DIGITS = 7;
   localparam int IDX_ENABLE = 0;
   localparam int IDX_MODE = 1;
   localparam int IDX_MODE2 = 2;
   localparam int IDX_CHAN_TENS = 3;
   localparam int IDX_CHAN_UNITS = 4;
   localparam int IDX_RANGE = 5;
   localparam int IDX_FILTER = 6;
   localparam logic [2:0] IDX_W = 3'h7;

   // Mode digit values
   localparam logic [3:0] MODE_STEP = 4'h1;
   localparam logic [3:0] MODE_SINGLE = 4'h2;
   localparam logic [3:0] MODE_RANDOM = 4'h3;
   localparam logic [3:0] MODE_CONT = 4'h4;

   localparam logic [3:0] RST_DIGIT = 4'h0;
   localparam logic [6:0] CHAN_FIRST = 7'h01;
   localparam logic [6:0] CHAN_HOME = 7'h00;

   typedef enum logic [1:0] {
      SPO_IDLE = 2'b00,
      SPO_RECV = 2'b01,
      SPO_HOMED = 2'b10
   } spo_state_t;

endpackage : spo_pkg

// ==== core/spo_digit_reg.sv ====
// Purpose: One held programming digit
// Assumes: Loaded only while a digit string is being received
// Notes: Cleared on each new output command unless a digit loads in the same cycle
module spo_digit_reg
   import spo_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic load,
   input wire logic [3:0] din,
   output logic [3:0] q
);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= RST_DIGIT;
      end else if (ce) begin
         if (load) begin
            q <= din;
         end else if (clr) begin
            q <= RST_DIGIT;
         end
      end
   end
endmodule // spo_digit_reg

// ==== core/spo_top.sv ====
// Purpose: Output command and digit string to scanner programming
// Assumes: All inputs synchronous to core_clk
// Notes: Scanner counter tracking mirrors the scanner's own sequence
module spo_top
   import spo_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic out_cmd,
   input wire logic digit_valid,
   input wire logic [3:0] digit,
   input wire logic transfer_done_low,
   input wire logic home_select_jumper,
   input wire logic scan_advance,
   output logic home_req,
   output logic store_strobe,
   output logic [3:0] scan_mode,
   output logic [6:0] last_channel,
   output logic [6:0] random_channel,
   output logic [3:0] range_code,
   output logic [3:0] filter_code,
   output logic [6:0] scan_channel
);

   // ************************************
   // Digit capture
   // ************************************
   spo_state_t state;
   logic [2:0] dig_idx;
   logic [3:0] dq [NUM_DIGITS];
   logic done_q;
   logic done_fall;
   logic home_digits;
   logic [6:0] chan_bin;

   // Done is a level; only its falling edge ends a string
   assign done_fall = done_q && !transfer_done_low; // RULE11

   genvar g;
   generate
      for (g = 0; g < NUM_DIGITS; g++) begin : g_dig
         spo_digit_reg u_dig (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .ce(ce),
            .clr(out_cmd),
            .load(state == SPO_RECV && digit_valid &&
                  dig_idx == 3'(g)), // RULE8
            .din(digit),
            .q(dq[g])
         );
      end
   endgenerate

   // Home digits 1,8 seen; third digit onwards does not matter
   assign home_digits = state == SPO_RECV && digit_valid &&
                        dig_idx == 3'(IDX_MODE) &&
                        dq[IDX_ENABLE] == DIG_ENABLE &&
                        digit == DIG_HOME; // RULE5

   // Widen before the product so the tens weight cannot wrap at 4 bits
   assign chan_bin = 7'(dq[IDX_CHAN_TENS]) * 7'h0a +
                     7'(dq[IDX_CHAN_UNITS]);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         done_q <= 1'b1;
      end else if (ce) begin
         done_q <= transfer_done_low;
      end
   end

   // ************************************
   // Receive sequencer
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= SPO_IDLE;
         dig_idx <= 3'h0;
      end else if (ce) begin
         if (out_cmd) begin
            state <= SPO_RECV;
            dig_idx <= 3'h0;
         end else begin
            unique case (state)
               SPO_IDLE: begin
               end
               SPO_RECV: begin
                  if (done_fall) begin
                     state <= SPO_IDLE;
                  end else if (home_digits) begin
                     state <= SPO_HOMED; // RULE5
                  end else if (digit_valid && dig_idx != IDX_W) begin
                     dig_idx <= dig_idx + 3'h1;
                  end
               end
               SPO_HOMED: begin
                  // Trailing digits are swallowed
                  if (done_fall) begin
                     state <= SPO_IDLE; // RULE5
                  end
               end
               default: state <= SPO_IDLE;
            endcase
         end
      end
   end

   // ************************************
   // Home request and store strobe
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         home_req <= 1'b0;
      end else if (ce) begin
         home_req <= (out_cmd && home_select_jumper) || // RULE3 RULE7
                     home_digits; // RULE4 RULE5
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         store_strobe <= 1'b0;
      end else if (ce) begin
         // No strobe for a home-only string: nothing to store
         store_strobe <= state == SPO_RECV && done_fall; // RULE2
      end
   end

   // ************************************
   // Programming outputs
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scan_mode <= RST_DIGIT;
         last_channel <= CHAN_HOME;
         random_channel <= CHAN_HOME;
         range_code <= RST_DIGIT;
         filter_code <= RST_DIGIT;
      end else if (ce && state == SPO_RECV && done_fall) begin
         // Held from the strobe until the next non-home string completes
         scan_mode <= dq[IDX_MODE]; // RULE12
         range_code <= dq[IDX_RANGE];
         filter_code <= dq[IDX_FILTER];
         if (dq[IDX_MODE] == MODE_RANDOM) begin
            random_channel <= chan_bin; // RULE9
         end else begin
            last_channel <= chan_bin;
         end
      end
   end

   // ************************************
   // Scan channel tracking
   // ************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scan_channel <= CHAN_HOME;
      end else if (ce) begin
         if (home_req) begin
            scan_channel <= CHAN_HOME; // RULE6
         end else if (store_strobe && scan_mode == MODE_RANDOM) begin
            scan_channel <= random_channel; // RULE9
         end else if (scan_advance && scan_mode != MODE_RANDOM) begin
            if (scan_channel == CHAN_HOME ||
                scan_channel >= last_channel) begin
               scan_channel <= CHAN_FIRST; // RULE1 RULE7
            end else begin
               scan_channel <= scan_channel + CHAN_FIRST;
            end
         end
      end
   end

   // ************************************
   // Checks
   // ************************************
   a_strobe_on_done: assert property (@(posedge core_clk) // RULE2
      disable iff (!rst_n)
      ce && state == SPO_RECV && done_fall |=> store_strobe)
      else $error("no strobe after done");
   a_home_jumper: assert property (@(posedge core_clk) // RULE3
      disable iff (!rst_n)
      ce && out_cmd && home_select_jumper |=> home_req)
      else $error("jumper 8 command did not home");
   a_no_home_inv: assert property (@(posedge core_clk) // RULE4
      disable iff (!rst_n)
      ce && out_cmd && !home_select_jumper && state != SPO_RECV
      |=> !home_req)
      else $error("inverted jumper command homed");
   // A fresh command right behind the home digits may home again
   a_home_digits: assert property (@(posedge core_clk) // RULE5
      disable iff (!rst_n)
      ce && home_digits && !out_cmd |=> home_req ##1
      (!home_req || $past(out_cmd) || !$past(ce)))
      else $error("home digits not one pulse");
   a_home_clears: assert property (@(posedge core_clk) // RULE6
      disable iff (!rst_n)
      ce && home_req |=> scan_channel == CHAN_HOME)
      else $error("home left a channel closed");
   a_wrap_first: assert property (@(posedge core_clk) // RULE1
      disable iff (!rst_n)
      ce && !home_req && scan_advance && scan_mode != MODE_RANDOM &&
      scan_channel >= last_channel |=> scan_channel == CHAN_FIRST)
      else $error("no wrap to channel 1");
   a_random_chan: assert property (@(posedge core_clk) // RULE9
      disable iff (!rst_n)
      ce && !home_req && store_strobe && scan_mode == MODE_RANDOM
      |=> scan_channel == $past(random_channel))
      else $error("random channel not passed");
   a_hold_outputs: assert property (@(posedge core_clk) // RULE12
      disable iff (!rst_n)
      !(state == SPO_RECV && done_fall) |=> $stable(scan_mode))
      else $error("mode changed without strobe");
   a_home_after_adv: assert property (@(posedge core_clk) // RULE7
      disable iff (!rst_n)
      ce && !home_req && scan_advance && scan_mode != MODE_RANDOM &&
      scan_channel == CHAN_HOME |=> scan_channel == CHAN_FIRST)
      else $error("advance after home not channel 1");

   c_strobe: cover property (@(posedge core_clk) store_strobe);
   c_home_digits: cover property (@(posedge core_clk) home_digits);
   c_wrap: cover property (@(posedge core_clk)
      scan_advance && scan_channel == last_channel);
   c_random: cover property (@(posedge core_clk)
      store_strobe && scan_mode == MODE_RANDOM);

endmodule // spo_top

// ==== verif/spo_partner.sv ====
// Purpose: Digit source and scanner advance model for the output card
// Assumes: Drives just after the rising edge of core_clk
// Notes: Released digit lines show the inverse of the last digit
module spo_partner (
   input wire logic core_clk,
   output logic out_cmd,
   output logic digit_valid,
   output logic [3:0] digit,
   output logic transfer_done_low,
   output logic scan_advance
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************
   // Controller and scanner side
   // ************************************
   initial begin
      out_cmd = 1'b0;
      digit_valid = 1'b0;
      digit = 4'h0;
      transfer_done_low = 1'b1;
      scan_advance = 1'b0;
   end
   task automatic send(input logic [27:0] p, input int n);
      int i;
      @(posedge core_clk);
      #1 out_cmd = 1'b1;
      @(posedge core_clk);
      #1 out_cmd = 1'b0;
      for (i = 0; i < n; i++) begin
         digit_valid = 1'b1;
         digit = p[27-4*i -: 4];
         @(posedge core_clk);
         #1;
      end
      digit_valid = 1'b0;
      digit = ~digit; // Stale digit must not look valid
      transfer_done_low = 1'b0;
      @(posedge core_clk);
      #1 transfer_done_low = 1'b1;
   endtask
   task automatic advance();
      @(posedge core_clk);
      #1 scan_advance = 1'b1;
      @(posedge core_clk);
      #1 scan_advance = 1'b0;
   endtask
endmodule // spo_partner

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the scanner program output card
// Assumes: Partner model drives the controller and scanner side
// Notes: Pulse outputs are counted every clock, not sampled once
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top
   import spo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_n, ce, home_select_jumper;
   logic out_cmd, digit_valid, transfer_done_low, scan_advance;
   logic [3:0] digit, scan_mode, range_code, filter_code;
   logic home_req, store_strobe;
   logic [6:0] last_channel, random_channel, scan_channel;
   int failures = 0, compares = 0, n_home = 0, n_strobe = 0, h, s, i;
   spo_partner src (.core_clk(core_clk), .out_cmd(out_cmd),
      .digit_valid(digit_valid), .digit(digit),
      .transfer_done_low(transfer_done_low), .scan_advance(scan_advance));
   spo_top dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .out_cmd(out_cmd), .digit_valid(digit_valid), .digit(digit),
      .transfer_done_low(transfer_done_low),
      .home_select_jumper(home_select_jumper), .scan_advance(scan_advance),
      .home_req(home_req), .store_strobe(store_strobe),
      .scan_mode(scan_mode), .last_channel(last_channel),
      .random_channel(random_channel), .range_code(range_code),
      .filter_code(filter_code), .scan_channel(scan_channel));
   // ************************************
   // Clock, pulse counters, helpers
   // ************************************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (home_req === 1'b1) n_home++;
      if (store_strobe === 1'b1) n_strobe++;
   end
   task automatic settle();
      repeat (4) @(posedge core_clk);
      #1;
      h = n_home;
      s = n_strobe;
   endtask
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ************************************
   // Scenarios
   // ************************************
   task automatic t_cont();
      src.send(28'h1400320, 7);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("home_req", h + 1, n_home)
      `CHK("store_strobe", s + 1, n_strobe)
      `CHK("scan_mode", MODE_CONT, scan_mode)
      `CHK("last_channel", 7'h03, last_channel)
      `CHK("range_code", 4'h2, range_code)
      for (i = 0; i < 4; i++) begin
         src.advance();
         `CHK("scan_channel", 7'(i % 3 + 1), scan_channel)
      end
      $display("t_cont done");
   endtask
   task automatic t_restart();
      settle();
      src.advance();
      src.send(28'h1102700, 7);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("home_req", h + 1, n_home)
      `CHK("scan_channel", CHAN_HOME, scan_channel)
      `CHK("scan_mode", MODE_STEP, scan_mode)
      `CHK("last_channel", 7'h1b, last_channel)
      src.advance();
      `CHK("scan_channel", CHAN_FIRST, scan_channel)
      `CHK("last_channel", 7'h1b, last_channel)
      $display("t_restart done");
   endtask
   task automatic t_random();
      settle();
      src.send(28'h1301521, 7);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("store_strobe", s + 1, n_strobe)
      `CHK("scan_mode", MODE_RANDOM, scan_mode)
      `CHK("random_channel", 7'h0f, random_channel)
      `CHK("scan_channel", 7'h0f, scan_channel)
      `CHK("last_channel", 7'h1b, last_channel)
      `CHK("filter_code", 4'h1, filter_code)
      $display("t_random done");
   endtask
   task automatic t_jumper_low();
      @(posedge core_clk);
      #1 home_select_jumper = 1'b0;
      settle();
      src.send(28'h1202340, 7);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("home_req", h, n_home)
      `CHK("last_channel", 7'h17, last_channel)
      src.advance();
      settle();
      src.send(28'h1809999, 7);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("home_req", h + 1, n_home)
      `CHK("store_strobe", s, n_strobe)
      `CHK("range_code", 4'h4, range_code)
      `CHK("scan_channel", CHAN_HOME, scan_channel)
      $display("t_jumper_low done");
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      home_select_jumper = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1'b1;
      `CHK("scan_channel", CHAN_HOME, scan_channel)
      `CHK("scan_mode", 4'h0, scan_mode)
      settle();
      t_cont();
      t_restart();
      t_random();
      t_jumper_low();
      end_sim();
   end
endmodule // tb_top
